// File: core/tmr_map.svh
// Purpose: register offsets, field positions and reset values of the timer unit
// Assumes: 32-bit AHB-Lite words, one register per aligned word
// Notes:   channel n block starts at n * CH_STRIDE
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

`define TMR_CH_STRIDE   8'h20
`define TMR_OFF_CTRL    3'h0
`define TMR_OFF_PINIO   3'h1
`define TMR_OFF_CNT     3'h2
`define TMR_OFF_STAT    3'h3
`define TMR_OFF_GRA     3'h4
`define TMR_ADDR_START  8'ha0
`define TMR_ADDR_SYNC   8'ha4
`define TMR_ADDR_LAST_CH 8'h9f

// control register fields
`define TMR_CTL_PS      2:0
`define TMR_CTL_CS      5:3
`define TMR_CTL_PWM     6
`define TMR_CTL_BUFA    7
`define TMR_CTL_BUFB    8
`define TMR_CTL_PHASE   9
`define TMR_CTL_OVIE    10
`define TMR_CTL_W       11

// status register fields
`define TMR_ST_OVF      4
`define TMR_ST_UNF      5

`define TMR_CTL_RST     11'h000
`define TMR_PINIO_RST   16'h0000
`define TMR_CNT_RST     16'h0000
`define TMR_GR_RST      16'hffff
`define TMR_PRE_W       6

`endif

// File: core/tmr_pkg.sv
// Purpose: types shared by the timer unit
// Assumes: map header carries all numbers
// Notes:   none
package tmr_pkg;
    typedef enum logic [2:0] {
        TMR_PS_DIV1  = 3'h0,
        TMR_PS_DIV4  = 3'h1,
        TMR_PS_DIV16 = 3'h2,
        TMR_PS_DIV64 = 3'h3,
        TMR_PS_CASC  = 3'h7
    } tmr_prescale_t;

    typedef enum logic [1:0] {
        TMR_LVL_HOLD   = 2'h0,
        TMR_LVL_LOW    = 2'h1,
        TMR_LVL_HIGH   = 2'h2,
        TMR_LVL_TOGGLE = 2'h3
    } tmr_level_t;
endpackage

// File: core/tmr_core.sv
// Purpose: five-channel 16-bit timer with sync, buffer, cascade and pwm mode 1
// Assumes: AHB-Lite slave, single word transfers, pins asynchronous to hclk
// Notes:   zero wait states; writes land one cycle after the address phase
//
// Operation
// - counter write presets all synchronized counters
// - synchronized counters clear together
// - channels zero to four join sync group
// - clear source field offers synchronous clearing
// - counting starts only after start bit set
// - input capture may clear the counter
// - buffering only channels 0,3,4: C->A, D->B
// - compare match copies buffer into general register
// - capture shifts old general value into buffer
// - channels 1 and 2 form 32-bit counter
// - channel 1 counts channel 2 overflow/underflow
// - underflow only in phase counting mode
// - phase mode channel ignores cascade clock
// - compare match drives pin low/high/toggle
// - duty from 0% to 100% possible
// - pwm per channel, sync allowed, clear sets period
// - pin A from A/B, pin C from C/D
// - pwm pin starts at A or C initial
// - equal pair values leave output unchanged
// - up to ten pwm phases at once
// - clearing match sets flag, counter to zero
// - wrap sets overflow flag, requests if enabled
`include "tmr_map.svh"
`timescale 1ns/10ps
`default_nettype none

module tmr_core
    import tmr_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int NCH   = 5
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [NCH-1:0]    pin_a_in,
    input  wire logic [NCH-1:0]    pin_b_in,
    input  wire logic [NCH-1:0]    pin_c_in,
    input  wire logic [NCH-1:0]    pin_d_in,
    output logic      [NCH-1:0]    pin_a_out,
    output logic      [NCH-1:0]    pin_b_out,
    output logic      [NCH-1:0]    pin_c_out,
    output logic      [NCH-1:0]    pin_d_out,
    output logic      [NCH-1:0]    pin_a_oe,
    output logic      [NCH-1:0]    pin_b_oe,
    output logic      [NCH-1:0]    pin_c_oe,
    output logic      [NCH-1:0]    pin_d_oe,
    input  wire logic [1:0]        phase_in_a,
    input  wire logic [1:0]        phase_in_b,
    output logic      [NCH-1:0]    overflow_req
);

    initial begin
        if (CNT_W != 16 || NCH != 5) begin
            $error("tmr_core serves 16-bit counters and five channels only");
        end
    end

    ////////////////////////////////////
    // bus slave

    logic              wr_q;
    logic [7:0]        waddr_q;
    logic [31:0]       rdata_d;
    logic              acc;

    assign acc = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q      <= 1'b0;
            waddr_q   <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_q      <= acc & hwrite;
            waddr_q   <= haddr;
            hrdata    <= (acc & ~hwrite) ? rdata_d : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////
    // global registers and prescaler

    logic [NCH-1:0]          start_q;
    logic [NCH-1:0]          sync_q;
    logic [`TMR_PRE_W-1:0]   pre_q;
    logic [3:0]              pre_tick;
    logic                    wr_ch;
    logic [2:0]              wr_idx;
    logic [2:0]              wr_reg;

    assign wr_ch  = wr_q && (waddr_q <= `TMR_ADDR_LAST_CH);
    assign wr_idx = waddr_q[7:5];
    assign wr_reg = waddr_q[4:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_q <= 5'h00;
            sync_q  <= 5'h00;
        end else if (wr_q && waddr_q == `TMR_ADDR_START) begin
            start_q <= hwdata[NCH-1:0];
        end else if (wr_q && waddr_q == `TMR_ADDR_SYNC) begin
            sync_q <= hwdata[NCH-1:0];
        end
    end

    // one divider feeds every channel, so synchronized channels share ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 6'h00;
        end else begin
            pre_q <= pre_q + 6'h01;
        end
    end

    assign pre_tick[0] = 1'b1;
    assign pre_tick[1] = &pre_q[1:0];
    assign pre_tick[2] = &pre_q[3:0];
    assign pre_tick[3] = &pre_q[5:0];

    ////////////////////////////////////
    // shared per-channel state

    logic [CNT_W-1:0]           cnt_q   [NCH];
    logic [CNT_W-1:0]           gr_q    [NCH][4];
    logic [`TMR_CTL_W-1:0]      ctl_q   [NCH];
    logic [15:0]                io_q    [NCH];
    logic [5:0]                 st_q    [NCH];
    logic [NCH-1:0]             own_clr;
    logic [NCH-1:0]             ovf;
    logic [NCH-1:0]             unf;
    logic [3:0]                 ph_s1, ph_s2, ph_s3;

    // b phases sit in bits 3:2, a phases in 1:0; third flop only for edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_s1 <= 4'h0;
            ph_s2 <= 4'h0;
            ph_s3 <= 4'h0;
        end else begin
            ph_s1 <= {phase_in_b, phase_in_a};
            ph_s2 <= ph_s1;
            ph_s3 <= ph_s2;
        end
    end

    ////////////////////////////////////
    // channels

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        localparam bit HAS_BUF = (i == 0) || (i == 3) || (i == 4);
        localparam bit HAS_PH  = (i == 1) || (i == 2);

        logic [3:0]  pin_s1, pin_s2, pin_s3;
        logic [3:0]  pin_in;
        logic [3:0]  lvl_q;
        logic [3:0]  oe_q;
        logic [3:0]  match;
        logic [3:0]  cap;
        logic [3:0]  ev;
        logic [2:0]  ps;
        logic [2:0]  cs;
        logic        phm;
        logic        tick;
        logic        up;
        logic        sync_clr;
        logic        clr;
        logic        ph_step;
        logic        ph_up;
        logic        cnt_wr;
        logic        ch_wr;

        assign pin_in = {pin_d_in[i], pin_c_in[i], pin_b_in[i], pin_a_in[i]};
        assign ch_wr  = wr_ch && (wr_idx == i);
        assign ps     = ctl_q[i][`TMR_CTL_PS];
        assign cs     = ctl_q[i][`TMR_CTL_CS];
        assign phm    = HAS_PH && ctl_q[i][`TMR_CTL_PHASE];

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pin_s1 <= 4'h0;
                pin_s2 <= 4'h0;
                pin_s3 <= 4'h0;
            end else begin
                pin_s1 <= pin_in;
                pin_s2 <= pin_s1;
                pin_s3 <= pin_s2;
            end
        end

        // quadrature decode of the synchronized phase pair, any edge counts
        if (HAS_PH) begin : g_ph
            assign ph_step = (ph_s2[i-1] ^ ph_s3[i-1]) | (ph_s2[i+1] ^ ph_s3[i+1]);
            assign ph_up   = ph_s3[i-1] ^ ph_s2[i+1];
        end else begin : g_noph
            assign ph_step = 1'b0;
            assign ph_up   = 1'b1;
        end

        always_comb begin
            tick = 1'b0;
            up   = 1'b1;
            if (!start_q[i]) begin
                tick = 1'b0;
            end else if (phm) begin
                tick = ph_step;
                up   = ph_up;
            end else if (ps == TMR_PS_CASC) begin
                tick = (i == 1) && (ovf[2] || unf[2]);
                up   = ovf[2];
            end else if (ps[2] == 1'b0) begin
                tick = pre_tick[ps[1:0]];
            end
        end

        for (genvar k = 0; k < 4; k++) begin : g_ev
            logic [3:0] f;
            assign f        = io_q[i][4*k +: 4];
            assign match[k] = tick && !f[3] && (cnt_q[i] == gr_q[i][k]);
            assign cap[k]   = f[3] && (f[1] ? (pin_s2[k] ^ pin_s3[k])
                                            : f[0] ? (pin_s3[k] & ~pin_s2[k])
                                                   : (pin_s2[k] & ~pin_s3[k]));
        end

        assign ev         = match | cap;
        assign own_clr[i] = (cs[1:0] != 2'h0) && (cs[1:0] != 2'h3)
                            && ev[{cs[2], cs[1]}];
        assign sync_clr   = sync_q[i] && (cs[1:0] == 2'h3)
                            && |(own_clr & sync_q);
        assign clr        = own_clr[i] || sync_clr;
        assign ovf[i]     = tick && up && (&cnt_q[i]);
        assign unf[i]     = tick && !up && phm && (cnt_q[i] == 16'h0000);
        assign cnt_wr     = wr_ch && (wr_reg == `TMR_OFF_CNT)
                            && ((wr_idx == i) || (sync_q[i] && sync_q[wr_idx]));

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ctl_q[i] <= `TMR_CTL_RST;
                io_q[i]  <= `TMR_PINIO_RST;
            end else if (ch_wr && wr_reg == `TMR_OFF_CTRL) begin
                ctl_q[i] <= hwdata[`TMR_CTL_W-1:0];
            end else if (ch_wr && wr_reg == `TMR_OFF_PINIO) begin
                io_q[i] <= hwdata[15:0];
            end
        end

        // bus preset outranks a clear, a clear outranks a count step
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cnt_q[i] <= `TMR_CNT_RST;
            end else if (cnt_wr) begin
                cnt_q[i] <= hwdata[CNT_W-1:0];
            end else if (clr) begin
                cnt_q[i] <= 16'h0000;
            end else if (tick) begin
                cnt_q[i] <= up ? cnt_q[i] + 16'h0001 : cnt_q[i] - 16'h0001;
            end
        end

        // flags: write 1 clears, a new event in the same cycle wins
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                st_q[i] <= 6'h00;
            end else begin
                st_q[i] <= {unf[i], ovf[i], ev} | (st_q[i]
                    & ~((ch_wr && wr_reg == `TMR_OFF_STAT) ? hwdata[5:0] : 6'h00));
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                overflow_req[i] <= 1'b0;
            end else begin
                overflow_req[i] <= st_q[i][`TMR_ST_OVF] && ctl_q[i][`TMR_CTL_OVIE];
            end
        end

        // general registers; hardware transfers take precedence over the bus
        for (genvar k = 0; k < 4; k++) begin : g_gr
            logic buf_on;
            // A and C share one buffer enable, B and D the other
            assign buf_on = HAS_BUF && ctl_q[i][`TMR_CTL_BUFA + k % 2];
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    gr_q[i][k] <= `TMR_GR_RST;
                end else if (cap[k]) begin
                    gr_q[i][k] <= cnt_q[i];
                end else if (k < 2 && buf_on && match[k]) begin
                    gr_q[i][k] <= gr_q[i][(k + 2) % 4];
                end else if (k >= 2 && buf_on && cap[(k + 2) % 4]) begin
                    gr_q[i][k] <= gr_q[i][(k + 2) % 4];
                end else if (ch_wr && wr_reg == `TMR_OFF_GRA + k) begin
                    gr_q[i][k] <= hwdata[CNT_W-1:0];
                end
            end
        end

        // pin levels; pwm pairs A/B onto pin A and C/D onto pin C
        for (genvar k = 0; k < 4; k++) begin : g_pin
            logic [3:0] fp;
            logic [3:0] fs;
            logic       pwm_pin;
            logic       pwm_off;
            logic       hit_p;
            logic       hit_s;
            assign fp      = io_q[i][4*k +: 4];
            assign fs      = io_q[i][4*(k+1) % 16 +: 4];
            assign pwm_pin = ctl_q[i][`TMR_CTL_PWM] && (k == 0 || k == 2);
            assign pwm_off = ctl_q[i][`TMR_CTL_PWM] && (k == 1 || k == 3);
            assign hit_p   = match[k];
            assign hit_s   = pwm_pin && match[(k + 1) % 4];
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    lvl_q[k] <= 1'b0;
                    oe_q[k]  <= 1'b0;
                end else begin
                    oe_q[k] <= !fp[3] && (fp[1:0] != 2'h0) && !pwm_off;
                    if (!start_q[i]) begin
                        lvl_q[k] <= fp[2];
                    end else if (hit_p && hit_s) begin
                        lvl_q[k] <= lvl_q[k];
                    end else if (hit_p || hit_s) begin
                        // the pair's second match applies its own level field
                        case (tmr_level_t'(hit_s ? fs[1:0] : fp[1:0]))
                            TMR_LVL_LOW:    lvl_q[k] <= 1'b0;
                            TMR_LVL_HIGH:   lvl_q[k] <= 1'b1;
                            TMR_LVL_TOGGLE: lvl_q[k] <= ~lvl_q[k];
                            default:        lvl_q[k] <= lvl_q[k];
                        endcase
                    end
                end
            end
        end

        assign {pin_d_out[i], pin_c_out[i], pin_b_out[i], pin_a_out[i]} = lvl_q;
        assign {pin_d_oe[i], pin_c_oe[i], pin_b_oe[i], pin_a_oe[i]}     = oe_q;
    end

    ////////////////////////////////////
    // read mux; unmapped words read zero

    always_comb begin
        logic [2:0] ri;
        logic [2:0] rr;
        ri      = haddr[7:5];
        rr      = haddr[4:2];
        rdata_d = 32'h0000_0000;
        if (haddr == `TMR_ADDR_START) begin
            rdata_d = {27'h0, start_q};
        end else if (haddr == `TMR_ADDR_SYNC) begin
            rdata_d = {27'h0, sync_q};
        end else if (haddr <= `TMR_ADDR_LAST_CH) begin
            if (rr == `TMR_OFF_CTRL) begin
                rdata_d = {21'h0, ctl_q[ri]};
            end else if (rr == `TMR_OFF_PINIO) begin
                rdata_d = {16'h0, io_q[ri]};
            end else if (rr == `TMR_OFF_CNT) begin
                rdata_d = {16'h0, cnt_q[ri]};
            end else if (rr == `TMR_OFF_STAT) begin
                rdata_d = {26'h0, st_q[ri]};
            end else begin
                rdata_d = {16'h0, gr_q[ri][rr[1:0]]};
            end
        end
    end

endmodule

`default_nettype wire

// File: verif/tmr_pin_model.sv
// Purpose: far side of the timer pins: capture edges and a two-phase encoder
// Assumes: commands from the bench arrive just after a rising edge
// Notes:   drives channel 0 pin a and the channel 2 encoder
`timescale 1ns/10ps
`default_nettype none

module tmr_pin_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [4:0] cap_cmd,
    input  wire logic       step,
    input  wire logic       back,
    output logic      [4:0] pin_a_in,
    output logic      [4:0] pin_b_in,
    output logic      [4:0] pin_c_in,
    output logic      [4:0] pin_d_in,
    output logic      [1:0] phase_in_a,
    output logic      [1:0] phase_in_b
);
    logic [1:0] pos_q;

    ////////////////////////////////////
    // capture source: level follows the command one edge late
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_a_in <= 5'h00;
        end else begin
            pin_a_in <= cap_cmd;
        end
    end
    // unused pins sit at their idle low level
    assign pin_b_in = 5'h00;
    assign pin_c_in = 5'h00;
    assign pin_d_in = 5'h00;

    ////////////////////////////////////
    // encoder: gray position, b leads a when stepping forward
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_q <= 2'h0;
        end else if (step) begin
            pos_q <= back ? pos_q - 2'h1 : pos_q + 2'h1;
        end
    end
    assign phase_in_a = {pos_q[1], 1'b0};
    assign phase_in_b = {pos_q[1] ^ pos_q[0], 1'b0};
endmodule

`default_nettype wire

// File: verif/tmr_core_assertions.sv
// Purpose: port-level checks of the timer core
// Assumes: settings are shadowed from bus writes
// Notes:   only software-set fields are shadowed
`timescale 1ns/10ps
`default_nettype none

module tmr_chk #(
    parameter int CNT_W = 16,
    parameter int NCH   = 5
) (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    input  wire logic           hsel,
    input  wire logic [7:0]     haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic           hready,
    input  wire logic [31:0]    hwdata,
    input  wire logic [NCH-1:0] pin_a_out,
    input  wire logic [NCH-1:0] pin_c_out,
    input  wire logic [NCH-1:0] pin_a_oe,
    input  wire logic [NCH-1:0] pin_b_oe,
    input  wire logic [NCH-1:0] pin_d_oe,
    input  wire logic [NCH-1:0] overflow_req
);
    logic           wp_q;
    logic [7:0]     wa_q;
    logic [NCH-1:0] st_q;
    logic [10:0]    ctl_q [NCH];
    logic [15:0]    pio_q [NCH];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q <= 1'b0;
            wa_q <= 8'h00;
        end else begin
            wp_q <= hsel && htrans[1] && hready && hwrite;
            wa_q <= haddr;
        end
    end

    // write lands at the end of the data phase, same edge as in the core
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
            for (int i = 0; i < NCH; i++) begin
                ctl_q[i] <= 11'h000;
                pio_q[i] <= 16'h0000;
            end
        end else if (wp_q) begin
            if (wa_q == 8'ha0) st_q <= hwdata[NCH-1:0];
            for (int i = 0; i < NCH; i++) begin
                if (wa_q == 8'(i * 32)) ctl_q[i] <= hwdata[10:0];
                if (wa_q == 8'(i * 32 + 4)) pio_q[i] <= hwdata[15:0];
            end
        end
    end

    ////////////////////////////////////
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // two cycles of settling, three for the hold check: pins are registered after the setting lands
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        AST_STOP_A: assert property (
            (!st_q[g] && !pio_q[g][3] && $stable(pio_q[g])) [*2]
            |-> pin_a_out[g] == pio_q[g][2]) else $error("pin a not at initial level");
        AST_STOP_C: assert property (
            (!st_q[g] && !pio_q[g][11] && $stable(pio_q[g])) [*2]
            |-> pin_c_out[g] == pio_q[g][10]) else $error("pin c not at initial level");
        AST_STOP_HOLD: assert property (
            (!st_q[g] && $stable(pio_q[g]) && $stable(ctl_q[g])) [*3]
            |-> $stable(pin_a_out[g])) else $error("stopped channel moved its pin");
        AST_PWM_B: assert property (
            ctl_q[g][6] [*2] |-> !pin_b_oe[g]) else $error("pin b driven in pwm mode");
        AST_PWM_D: assert property (
            ctl_q[g][6] [*2] |-> !pin_d_oe[g]) else $error("pin d driven in pwm mode");
        AST_CAP_A: assert property (
            pio_q[g][3] [*2] |-> !pin_a_oe[g]) else $error("capture pin a driven");
        AST_OV_EN: assert property (
            $rose(overflow_req[g]) |-> $past(ctl_q[g][10]))
            else $error("overflow request without enable");
        AST_OV_OFF: assert property (
            !ctl_q[g][10] [*2] |-> !overflow_req[g]) else $error("overflow request while off");
    end
endmodule

bind tmr_core tmr_chk #(.CNT_W(CNT_W), .NCH(NCH)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .pin_a_out(pin_a_out),
    .pin_c_out(pin_c_out), .pin_a_oe(pin_a_oe), .pin_b_oe(pin_b_oe),
    .pin_d_oe(pin_d_oe), .overflow_req(overflow_req));

`default_nettype wire

// File: verif/timer_sync_buffer_cascade_pwm_bench.sv
// Purpose: directed register tests of the timer core
// Assumes: master waits on hready
// Notes:   counters are read while stopped, or while the encoder rests between steps
`timescale 1ns/10ps
`default_nettype none

module timer_sync_buffer_cascade_pwm_bench;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, step, back;
    logic [1:0]  htrans, ph_a, ph_b;
    logic [2:0]  hsize;
    logic [7:0]  haddr;
    logic [31:0] hwdata, hrdata, rv, g, n;
    logic [4:0]  cap_cmd, pa_in, pb_in, pc_in, pd_in, pa_out, ovr;
    int          fail_count, cmp_count, cyc;

    tmr_core #(.CNT_W(16), .NCH(5)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .pin_a_in(pa_in), .pin_b_in(pb_in), .pin_c_in(pc_in), .pin_d_in(pd_in),
        .pin_a_out(pa_out), .pin_b_out(), .pin_c_out(), .pin_d_out(),
        .pin_a_oe(), .pin_b_oe(), .pin_c_oe(), .pin_d_oe(),
        .phase_in_a(ph_a), .phase_in_b(ph_b), .overflow_req(ovr));

    tmr_pin_model u_pins (
        .hclk(hclk), .hresetn(hresetn), .cap_cmd(cap_cmd), .step(step), .back(back),
        .pin_a_in(pa_in), .pin_b_in(pb_in), .pin_c_in(pc_in), .pin_d_in(pd_in),
        .phase_in_a(ph_a), .phase_in_b(ph_b));

    always #10 hclk = ~hclk;

    ////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hung handshake ends up here instead of running forever
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            finish_test();
        end
    end

    function automatic logic [7:0] ra(input int c, input int o);
        return 8'(c * 32 + o * 4);
    endfunction

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, rv, e);
    endtask

    task automatic pulse();
        @(posedge hclk);
        cap_cmd <= 5'h01;
        repeat (4) @(posedge hclk);
        cap_cmd <= 5'h00;
    endtask

    task automatic quad(input logic b, input int k);
        repeat (k) begin
            @(posedge hclk);
            step <= 1'b1;
            back <= b;
            @(posedge hclk);
            step <= 1'b0;
            repeat (4) @(posedge hclk);
        end
    endtask

    ////////////////////////////////////
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 8'h00;
        hwdata = 32'h0;
        cap_cmd = 5'h00;
        step = 1'b0;
        back = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdc("start", 8'ha0, 32'h0);
        rdc("gra0", ra(0, 4), 32'hffff);
        rdc("unmapped", 8'hfc, 32'h0);
        // group without channel 1: its counter must keep its value
        wr(8'ha4, 32'h1d);
        wr(ra(2, 2), 32'h1234);
        for (int c = 0; c < 5; c++) begin
            rdc("preset", ra(c, 2), (c == 1) ? 32'h0 : 32'h1234);
        end
        repeat (10) @(posedge hclk);
        rdc("stopped", ra(0, 2), 32'h1234);
        // period on a, buffer c->a, channel 1 follows by sync clear
        wr(8'ha4, 32'h03);
        wr(ra(0, 2), 32'h0);
        wr(ra(0, 0), 32'h88);
        wr(ra(1, 0), 32'h18);
        wr(ra(0, 4), 32'h9);
        wr(ra(0, 6), 32'h5);
        wr(8'ha0, 32'h03);
        repeat (40) @(posedge hclk);
        wr(8'ha0, 32'h0);
        rdc("gra0", ra(0, 4), 32'h5);
        bus(1'b0, ra(0, 2), 32'h0);
        g = rv;
        chk("period", 32'(rv < 32'd6), 32'h1);
        rdc("sync", ra(1, 2), g);
        bus(1'b0, ra(0, 3), 32'h0);
        chk("matchflag", {31'h0, rv[0]}, 32'h1);
        // wrap of channel 3 with its overflow request enabled
        wr(8'ha4, 32'h0);
        wr(ra(3, 0), 32'h400);
        wr(ra(3, 2), 32'hfff0);
        wr(8'ha0, 32'h08);
        repeat (30) @(posedge hclk);
        chk("ovreq", {31'h0, ovr[3]}, 32'h1);
        bus(1'b0, ra(3, 3), 32'h0);
        chk("ovflag", {31'h0, rv[4]}, 32'h1);
        wr(ra(3, 3), 32'h10);
        repeat (3) @(posedge hclk);
        chk("ovclr", {31'h0, ovr[3]}, 32'h0);
        wr(8'ha0, 32'h0);
        // pwm on channel 4: period 8 from b, then equal pair at both levels
        wr(ra(4, 2), 32'h0);
        wr(ra(4, 0), 32'h50);
        wr(ra(4, 5), 32'h7);
        for (int k = 0; k < 3; k++) begin
            wr(ra(4, 4), (k == 0) ? 32'h3 : 32'h7);
            wr(ra(4, 1), (k == 2) ? 32'h16 : 32'h12);
            wr(8'ha0, 32'h10);
            repeat (16) @(posedge hclk);
            n = 32'h0;
            repeat (32) begin
                @(posedge hclk);
                n = n + {31'h0, pa_out[4]};
            end
            chk("duty", n, (k == 0) ? 32'd16 : ((k == 1) ? 32'd0 : 32'd32));
            wr(8'ha0, 32'h0);
            repeat (3) @(posedge hclk);
            chk("initial", {31'h0, pa_out[4]}, (k == 2) ? 32'h1 : 32'h0);
        end
        // capture on pin a of channel 0, clearing and shifting into c
        wr(ra(0, 1), 32'h8);
        wr(ra(0, 4), 32'h100);
        wr(8'ha0, 32'h01);
        repeat (100) @(posedge hclk);
        pulse();
        repeat (10) @(posedge hclk);
        rdc("grc0", ra(0, 6), 32'h100);
        bus(1'b0, ra(0, 4), 32'h0);
        g = rv;
        repeat (30) @(posedge hclk);
        pulse();
        repeat (10) @(posedge hclk);
        wr(8'ha0, 32'h0);
        rdc("grc0", ra(0, 6), g);
        bus(1'b0, ra(0, 4), 32'h0);
        chk("capclear", 32'(rv < 32'd80), 32'h1);
        // cascade: encoder on channel 2 carries into channel 1
        wr(ra(2, 0), 32'h200);
        wr(ra(1, 0), 32'h7);
        wr(ra(2, 2), 32'hfffd);
        wr(ra(1, 2), 32'h0);
        wr(8'ha0, 32'h06);
        quad(1'b0, 4);
        repeat (6) @(posedge hclk);
        rdc("lower", ra(2, 2), 32'h1);
        rdc("upper", ra(1, 2), 32'h1);
        quad(1'b1, 4);
        repeat (6) @(posedge hclk);
        rdc("lower", ra(2, 2), 32'hfffd);
        rdc("upper", ra(1, 2), 32'h0);
        wr(8'ha0, 32'h0);
        finish_test();
    end
endmodule

`default_nettype wire
